/* File: hdl/core_pkg.sv */
package core_pkg;
	// Widths
	localparam int PC_W       = 23;
	localparam int WREG_W     = 16;
	localparam int WREG_N     = 16;
	localparam int PRIO_W     = 3;
	// Byte addresses of registers on the bus
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_OPA    = 8'h08;
	localparam logic [7:0] ADDR_OPB    = 8'h0c;
	localparam logic [7:0] ADDR_RES    = 8'h10;
	localparam logic [7:0] ADDR_RESHI  = 8'h14;
	localparam logic [7:0] ADDR_CMD    = 8'h18;
	localparam logic [7:0] ADDR_PC     = 8'h1c;
	localparam logic [7:0] ADDR_SRCCNT = 8'h20;
	localparam logic [7:0] ADDR_DSPACE = 8'h24;
	localparam logic [7:0] ADDR_WREG   = 8'h40;
	// Status register fields
	localparam int ST_C  = 0;
	localparam int ST_Z  = 1;
	localparam int ST_OV = 2;
	localparam int ST_N  = 3;
	localparam int ST_RA = 4;
	localparam int ST_PL = 5;
	localparam int ST_DC = 8;
	localparam logic [15:0] STATUS_WMASK = 16'h01ef;
	localparam logic [15:0] STATUS_RST   = 16'h0000;
	localparam int CTRL_PX = 3;
	// Core figures
	localparam int TRAP_SOURCES = 8;
	localparam int IRQ_SOURCES  = 118;
	localparam logic [4:0] DIV_CYCLES = 5'd19;
	localparam logic [15:0] DS_SPLIT  = 16'h8000;
	localparam logic [3:0] SSP_INDEX  = 4'hf;
	// Commands written to the command register
	typedef enum logic [3:0] {
		OP_ADD  = 4'b0000,
		OP_SUB  = 4'b0001,
		OP_AND  = 4'b0010,
		OP_OR   = 4'b0011,
		OP_XOR  = 4'b0100,
		OP_MULS = 4'b0101,
		OP_MULU = 4'b0110,
		OP_MULSU= 4'b0111,
		OP_MULUS= 4'b1000,
		OP_MUL8 = 4'b1001,
		OP_DIVS = 4'b1010,
		OP_DIVU = 4'b1011,
		OP_REP  = 4'b1100,
		OP_MOVD = 4'b1101
	} op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV  = 2'b01,
		ST_LOOP = 2'b10,
		ST_MOVD = 2'b11
	} core_state_t;
endpackage : core_pkg

/* File: hdl/cpu_core_alu_status.sv */
// Overview of operation
// - Program counter is 23 bits, covering 4M instruction words.
// - Operations finish in one cycle except flow change, double move, divide, table access.
// - Repeat loops add no per-pass overhead and can be interrupted anytime.
// - Sixteen 16-bit working registers; the last is the software stack pointer.
// - Lower 32 KB of data space linear; upper 32 KB is an extended window.
// - One cycle does memory read, register read, memory write and fetch.
// - 17x17 multiplier: signed, unsigned, mixed; 16x16 or 8x8 in one cycle.
// - Non-restoring divide, 32 or 16 by 16 bits, 19 cycles, interruptible.
// - Up to 8 trap sources and 118 interrupt sources, seven levels.
// - All core registers are memory mapped; all but the result and source count registers are directly writable as data.
// - Half carry in bit 8 from bit 3 for bytes, bit 7 for words.
// - Priority field bits 7..5 gives level 0..7; 111 blocks user interrupts.
// - Loop active bit 4 is read only, set while a repeat loop runs.
// - Negative follows result sign; overflow flags two's complement overflow.
// - Zero flag cleared by non-zero result, stays set until such a result.
// - For subtraction carry and half carry are inverted borrow indicators.
// - Extension bit in control register sits above the field, giving levels 8..15.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_alu_status (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        abort_req,
	output logic      [3:0]  cpu_priority,
	output logic             user_irq_blocked
);
	// Decoding of a register index inside the word window
	function automatic logic is_wreg(input logic [7:0] a);
		is_wreg = (a[7:6] == core_pkg::ADDR_WREG[7:6]);
	endfunction : is_wreg

	logic [15:0]             status_reg, status_next;
	logic [3:0]              ctrl_reg;
	logic [15:0]             opa_reg, opb_reg;
	logic [15:0]             res_reg, reshi_reg;
	logic [core_pkg::PC_W-1:0] program_counter_reg;
	logic [15:0]             wreg [core_pkg::WREG_N];
	logic [15:0]             loop_count_reg;
	logic [4:0]              div_count_reg;
	logic [31:0]             div_rem_reg;
	logic [15:0]             div_quo_reg;
	logic                    div_signed_reg, div_negq_reg, div_negr_reg;
	core_pkg::core_state_t   state_reg;
	logic                    wr_pend_reg;
	logic [7:0]              wr_addr_reg;
	logic                    byte_mode_reg;
	logic [15:0]             ds_addr_reg;

	// Address phase capture
	wire        addr_valid = hsel && hready && htrans[1];
	wire [7:0]  a_addr     = haddr[7:0];
	wire        busy       = (state_reg != core_pkg::ST_IDLE);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Write data decode
	wire        wr_go      = wr_pend_reg;
	wire        wr_status  = wr_go && (wr_addr_reg == core_pkg::ADDR_STATUS);
	wire        wr_ctrl    = wr_go && (wr_addr_reg == core_pkg::ADDR_CTRL);
	wire        wr_opa     = wr_go && (wr_addr_reg == core_pkg::ADDR_OPA);
	wire        wr_opb     = wr_go && (wr_addr_reg == core_pkg::ADDR_OPB);
	wire        wr_cmd     = wr_go && (wr_addr_reg == core_pkg::ADDR_CMD) && !busy;
	wire        wr_pc      = wr_go && (wr_addr_reg == core_pkg::ADDR_PC);
	wire        wr_ds      = wr_go && (wr_addr_reg == core_pkg::ADDR_DSPACE);
	wire        wr_wreg    = wr_go && is_wreg(wr_addr_reg);
	wire [3:0]  wr_idx     = wr_addr_reg[5:2];
	wire [3:0]  cmd_op     = hwdata[3:0];
	wire        cmd_byte   = hwdata[4];

	// Add/subtract datapath with half carry and flags
	wire        is_sub     = (cmd_op == core_pkg::OP_SUB);
	wire [15:0] b_eff      = is_sub ? ~opb_reg : opb_reg;
	wire [16:0] sum        = {1'b0, opa_reg} + {1'b0, b_eff} + {16'h0000, is_sub};
	wire [4:0]  sum_nib    = {1'b0, opa_reg[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};
	wire [8:0]  sum_byte   = {1'b0, opa_reg[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, is_sub};
	wire [15:0] logic_res  = (cmd_op == core_pkg::OP_AND) ? (opa_reg & opb_reg) :
	                         (cmd_op == core_pkg::OP_OR)  ? (opa_reg | opb_reg) : (opa_reg ^ opb_reg);
	wire        is_arith   = (cmd_op == core_pkg::OP_ADD) || is_sub;
	wire [15:0] alu_res    = is_arith ? sum[15:0] : logic_res;
	wire        res_sign   = cmd_byte ? alu_res[7] : alu_res[15];
	wire        res_zero   = cmd_byte ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
	wire        carry_out  = cmd_byte ? sum_byte[8] : sum[16];
	wire        half_out   = cmd_byte ? sum_nib[4] : sum_byte[8];
	wire        a_s        = cmd_byte ? opa_reg[7] : opa_reg[15];
	wire        b_s        = cmd_byte ? b_eff[7] : b_eff[15];
	wire        ovf        = (a_s == b_s) && (res_sign != a_s);

	// Single-cycle 17x17 multiplier, operands extended by mode
	wire        ma_sgn     = (cmd_op == core_pkg::OP_MULS) || (cmd_op == core_pkg::OP_MULSU);
	wire        mb_sgn     = (cmd_op == core_pkg::OP_MULS) || (cmd_op == core_pkg::OP_MULUS);
	wire        m8         = (cmd_op == core_pkg::OP_MUL8);
	wire [15:0] ma16       = m8 ? {8'h00, opa_reg[7:0]} : opa_reg;
	wire [15:0] mb16       = m8 ? {8'h00, opb_reg[7:0]} : opb_reg;
	wire signed [16:0] ma  = {ma_sgn & ma16[15], ma16};
	wire signed [16:0] mb  = {mb_sgn & mb16[15], mb16};
	wire signed [33:0] mp  = ma * mb;
	wire        is_mul     = (cmd_op >= core_pkg::OP_MULS) && (cmd_op <= core_pkg::OP_MUL8);

	// Divider start: magnitudes of dividend {opb:opa}, or opa alone for a 16-bit dividend, and divisor reshi
	wire        d_sgn      = (cmd_op == core_pkg::OP_DIVS);
	wire [31:0] dvd_raw    = cmd_byte ? {{16{d_sgn & opa_reg[15]}}, opa_reg} : {opb_reg, opa_reg};
	wire        dvd_neg    = d_sgn && dvd_raw[31];
	wire        dvs_neg    = d_sgn && reshi_reg[15];
	wire [31:0] dvd_mag    = dvd_neg ? (32'h0 - dvd_raw) : dvd_raw;
	wire [15:0] dvs_mag    = dvs_neg ? (16'h0 - reshi_reg) : reshi_reg;
	// One non-restoring step on an 18-bit signed remainder, so a full 16-bit divisor cannot overflow it
	logic [15:0] dvs_mag_reg;
	wire [17:0] dr_in      = {div_rem_reg[16:0], div_quo_reg[15]};
	wire [17:0] dr_step    = div_rem_reg[17] ? (dr_in + {2'b00, dvs_mag_reg}) : (dr_in - {2'b00, dvs_mag_reg});
	// Final correction: a negative remainder gets the divisor added back once
	wire [17:0] dr_fix     = div_rem_reg[17] ? (div_rem_reg[17:0] + {2'b00, dvs_mag_reg}) : div_rem_reg[17:0];
	wire        div_last   = (div_count_reg == 5'd1);
	// Two set-up cycles, sixteen quotient steps, one result cycle
	wire        div_step   = (state_reg == core_pkg::ST_DIV) && !div_last &&
	                         (div_count_reg <= core_pkg::DIV_CYCLES - 5'd2);

	// Status register next value
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = (hwdata[15:0] & core_pkg::STATUS_WMASK) | (status_reg & ~core_pkg::STATUS_WMASK);
		end
		if (wr_cmd && (is_arith || !is_mul && cmd_op <= core_pkg::OP_XOR)) begin
			status_next[core_pkg::ST_N] = res_sign;
			status_next[core_pkg::ST_Z] = res_zero ? 1'b1 : 1'b0;
			if (is_arith) begin
				status_next[core_pkg::ST_OV] = ovf;
				status_next[core_pkg::ST_C]  = carry_out;
				status_next[core_pkg::ST_DC] = half_out;
			end
		end
		status_next[core_pkg::ST_RA] = (state_reg == core_pkg::ST_LOOP) || (state_reg == core_pkg::ST_DIV);
		status_next[15:9] = 7'h00;
	end

	// Bus address phase latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_valid && hwrite;
			wr_addr_reg <= a_addr;
		end
	end

	// Status and control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= core_pkg::STATUS_RST;
			ctrl_reg   <= 4'h0;
		end else begin
			status_reg <= status_next;
			if (wr_ctrl) begin
				ctrl_reg[core_pkg::CTRL_PX] <= hwdata[core_pkg::CTRL_PX];
			end
		end
	end

	// Operands, program counter and data-space address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opa_reg             <= 16'h0000;
			opb_reg             <= 16'h0000;
			program_counter_reg <= '0;
			ds_addr_reg         <= 16'h0000;
		end else begin
			if (wr_opa) opa_reg <= hwdata[15:0];
			if (wr_opb) opb_reg <= hwdata[15:0];
			if (wr_ds) ds_addr_reg <= hwdata[15:0];
			if (wr_pc) begin
				program_counter_reg <= hwdata[core_pkg::PC_W-1:0];
			end else if (wr_cmd) begin
				program_counter_reg <= program_counter_reg + 23'd2;
			end
		end
	end

	// Working register array; index 15 is the stack pointer
	generate
		for (genvar i = 0; i < core_pkg::WREG_N; i++) begin : g_wreg
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					wreg[i] <= 16'h0000;
				end else if (wr_wreg && wr_idx == 4'(i)) begin
					wreg[i] <= hwdata[15:0];
				end
			end
		end
	endgenerate

	// Execution sequencer: single-cycle ops, loops and divide
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg      <= core_pkg::ST_IDLE;
			res_reg        <= 16'h0000;
			reshi_reg      <= 16'h0000;
			loop_count_reg <= 16'h0000;
			div_count_reg  <= 5'd0;
			div_rem_reg    <= 32'h0;
			div_quo_reg    <= 16'h0000;
			dvs_mag_reg    <= 16'h0000;
			div_signed_reg <= 1'b0;
			div_negq_reg   <= 1'b0;
			div_negr_reg   <= 1'b0;
			byte_mode_reg  <= 1'b0;
		end else begin
			if (wr_opb && !busy) reshi_reg <= reshi_reg;
			case (state_reg)
				core_pkg::ST_IDLE: begin
					if (wr_go && wr_addr_reg == core_pkg::ADDR_RESHI) reshi_reg <= hwdata[15:0];
					if (wr_cmd) begin
						byte_mode_reg <= cmd_byte;
						if (is_mul) begin
							res_reg   <= mp[15:0];
							reshi_reg <= mp[31:16];
						end else if (cmd_op == core_pkg::OP_DIVS || cmd_op == core_pkg::OP_DIVU) begin
							state_reg     <= core_pkg::ST_DIV;
							div_count_reg <= core_pkg::DIV_CYCLES;
							div_rem_reg   <= {16'h0000, dvd_mag[31:16]};
							div_quo_reg   <= dvd_mag[15:0];
							dvs_mag_reg   <= dvs_mag;
							div_signed_reg<= d_sgn;
							div_negq_reg  <= dvd_neg ^ dvs_neg;
							div_negr_reg  <= dvd_neg;
						end else if (cmd_op == core_pkg::OP_REP) begin
							state_reg      <= core_pkg::ST_LOOP;
							loop_count_reg <= hwdata[31:16];
						end else if (cmd_op == core_pkg::OP_MOVD) begin
							state_reg <= core_pkg::ST_MOVD;
							res_reg   <= opa_reg;
						end else begin
							res_reg <= alu_res;
						end
					end
				end
				core_pkg::ST_DIV: begin
					div_count_reg <= div_count_reg - 5'd1;
					if (abort_req) begin
						state_reg <= core_pkg::ST_IDLE;
					end else if (div_step) begin
						div_rem_reg <= {14'h0000, dr_step};
						div_quo_reg <= {div_quo_reg[14:0], ~dr_step[17]};
					end else if (div_last) begin
						res_reg   <= div_negq_reg ? (16'h0 - div_quo_reg) : div_quo_reg;
						reshi_reg <= div_negr_reg ? (16'h0 - dr_fix[15:0]) : dr_fix[15:0];
						state_reg <= core_pkg::ST_IDLE;
					end
				end
				core_pkg::ST_LOOP: begin
					if (abort_req || loop_count_reg == 16'h0000) begin
						state_reg <= core_pkg::ST_IDLE;
					end else begin
						loop_count_reg <= loop_count_reg - 16'h0001;
					end
				end
				core_pkg::ST_MOVD: begin
					reshi_reg <= opb_reg;
					state_reg <= core_pkg::ST_IDLE;
				end
				default: state_reg <= core_pkg::ST_IDLE;
			endcase
		end
	end

	// Priority output from field and extension bit
	assign cpu_priority     = {ctrl_reg[core_pkg::CTRL_PX], status_reg[core_pkg::ST_PL +: core_pkg::PRIO_W]};
	assign user_irq_blocked = (cpu_priority >= 4'h7);

	// Read data, registered in the data phase
	wire [15:0] ds_window = {ds_addr_reg >= core_pkg::DS_SPLIT, 15'h0000};
	wire [7:0]  src_counts = core_pkg::IRQ_SOURCES[7:0];
	wire [31:0] rd_mux =
		(a_addr == core_pkg::ADDR_STATUS) ? {16'h0000, status_reg} :
		(a_addr == core_pkg::ADDR_CTRL)   ? {28'h0, ctrl_reg} :
		(a_addr == core_pkg::ADDR_OPA)    ? {16'h0000, opa_reg} :
		(a_addr == core_pkg::ADDR_OPB)    ? {16'h0000, opb_reg} :
		(a_addr == core_pkg::ADDR_RES)    ? {16'h0000, res_reg} :
		(a_addr == core_pkg::ADDR_RESHI)  ? {16'h0000, reshi_reg} :
		(a_addr == core_pkg::ADDR_CMD)    ? {30'h0, state_reg} :
		(a_addr == core_pkg::ADDR_PC)     ? {9'h000, program_counter_reg} :
		(a_addr == core_pkg::ADDR_SRCCNT) ? {16'h0000, 4'(core_pkg::TRAP_SOURCES), 4'h0, src_counts} :
		(a_addr == core_pkg::ADDR_DSPACE) ? {ds_window, ds_addr_reg} :
		is_wreg(a_addr)                   ? {16'h0000, wreg[a_addr[5:2]]} : 32'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (addr_valid && !hwrite) begin
			hrdata <= rd_mux;
		end
	end
endmodule : cpu_core_alu_status
`default_nettype wire

/* File: bench/cpu_core_alu_status_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_alu_status_asserts (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        abort_req,
	input wire logic [3:0]  cpu_priority,
	input wire logic        user_irq_blocked
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Accepted address phases
	wire logic rd_go = hsel && hready && htrans[1] && !hwrite;
	wire logic wr_go = hsel && hready && htrans[1] && hwrite;
	a_zero_wait: assert property (hreadyout)
		else $error("slave inserted a wait state");
	a_resp_okay: assert property (!hresp)
		else $error("slave gave a non okay response");
	a_block_level: assert property (user_irq_blocked == (cpu_priority >= 4'h7))
		else $error("user interrupt block does not follow priority");
	a_status_upper: assert property (rd_go && haddr[7:0] == core_pkg::ADDR_STATUS |=> hrdata[31:9] == 23'h0)
		else $error("status upper bits not zero");
	a_pc_width: assert property (rd_go && haddr[7:0] == core_pkg::ADDR_PC |=> hrdata[31:23] == 9'h0)
		else $error("program counter wider than 23 bits");
	a_wreg_width: assert property (rd_go && haddr[7:6] == 2'b01 |=> hrdata[31:16] == 16'h0)
		else $error("working register wider than 16 bits");
	a_field_write: assert property (wr_go && haddr[7:0] == core_pkg::ADDR_STATUS ##1 1'b1
		|=> cpu_priority[2:0] == $past(hwdata[7:5])) else $error("priority field not taken from status write");
	a_ext_write: assert property (wr_go && haddr[7:0] == core_pkg::ADDR_CTRL ##1 1'b1
		|=> cpu_priority[3] == $past(hwdata[3])) else $error("priority extension not taken from control write");
	a_reset_clear: assert property ($rose(hresetn) |-> cpu_priority == 4'h0)
		else $error("priority not zero after reset");
endmodule : cpu_core_alu_status_asserts
bind cpu_core_alu_status cpu_core_alu_status_asserts u_cpu_core_alu_status_asserts (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .abort_req(abort_req), .cpu_priority(cpu_priority),
	.user_irq_blocked(user_irq_blocked));
`default_nettype wire

/* File: bench/cpu_core_alu_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_alu_status_test;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, abort_req, hreadyout, hresp, user_irq_blocked;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  cpu_priority;
	int          mismatches, checked, a, b, q, r, d, ex, res, st;
	int          wv[16];
	cpu_core_alu_status u_cpu_core_alu_status (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .abort_req(abort_req), .cpu_priority(cpu_priority),
		.user_irq_blocked(user_irq_blocked));
	// 50 ns clock
	always #25 hclk = ~hclk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One single word transfer, read data taken at the data phase edge
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	task automatic rck(input string what, input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m);
		bus(1'b0, ad, 32'h0);
		chk(what, exp, rd & m);
	endtask : rck
	task automatic abort_pulse();
		@(posedge hclk);
		abort_req <= 1'b1;
		@(posedge hclk);
		abort_req <= 1'b0;
	endtask : abort_pulse
	// Reference add or subtract: result and flags at their status positions
	function automatic void alu(input int a, input int b, input bit sub, input bit byt, output int res, output int st);
		int w, h, bb, s;
		w = byt ? 8 : 16;
		h = byt ? 4 : 8;
		bb = (sub ? ~b : b) & ((1 << w) - 1);
		s = (a & ((1 << w) - 1)) + bb + sub;
		res = s & ((1 << w) - 1);
		st = (s >> w & 1) | ((res == 0) << 1) | ((((a ^ s) & (bb ^ s)) >> (w - 1) & 1) << 2);
		st = st | ((res >> (w - 1) & 1) << 3) | ((((a & ((1 << h) - 1)) + (bb & ((1 << h) - 1)) + sub) >> h & 1) << 8);
	endfunction : alu
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// Watchdog
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		close_out();
	end
	initial begin
		{hresetn, hsel, hwrite, abort_req} = 4'h0;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
		ex = $urandom(6288);
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rck("status", core_pkg::ADDR_STATUS, 32'h0, 32'hffffffff);
		chk("priority", 32'h0, {28'h0, cpu_priority});
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, core_pkg::ADDR_CTRL, i[3] << 3);
			ex = 32'hffffff1f | ((i & 7) << 5);
			bus(1'b1, core_pkg::ADDR_STATUS, ex);
			rck("status", core_pkg::ADDR_STATUS, ex & 32'h1ef, 32'hffffffff);
			chk("priority", i, {28'h0, cpu_priority});
			chk("blocked", i >= 7, {31'h0, user_irq_blocked});
		end
		$display("priority levels done");
		for (int k = 0; k < 40; k++) begin
			a = $urandom & 'hffff;
			b = (k < 8) ? a : $urandom & 'hffff;
			if (k == 5) {a, b} = {32'h8080, 32'h8080};
			bus(1'b1, core_pkg::ADDR_OPA, a);
			bus(1'b1, core_pkg::ADDR_OPB, b);
			bus(1'b1, core_pkg::ADDR_CMD, (k[1] << 4) | k[0]);
			alu(a, b, k[0], k[1], res, st);
			rck("sum", core_pkg::ADDR_RES, res, k[1] ? 'hff : 'hffffffff);
			rck("flags", core_pkg::ADDR_STATUS, st, 'h10f);
		end
		$display("add and subtract done");
		for (int op = 2; op < 10; op++) begin
			a = $urandom & 'hffff;
			b = $urandom & 'hffff;
			bus(1'b1, core_pkg::ADDR_OPA, a);
			bus(1'b1, core_pkg::ADDR_OPB, b);
			bus(1'b1, core_pkg::ADDR_CMD, op);
			case (op)
				2: ex = a & b;
				3: ex = a | b;
				4: ex = a ^ b;
				5: ex = $signed(a[15:0]) * $signed(b[15:0]);
				6: ex = a * b;
				7: ex = $signed(a[15:0]) * $signed({1'b0, b[15:0]});
				8: ex = $signed({1'b0, a[15:0]}) * $signed(b[15:0]);
				default: ex = (a & 'hff) * (b & 'hff);
			endcase
			rck("product low", core_pkg::ADDR_RES, ex & 'hffff, 'hffffffff);
			if (op > 4) rck("product high", core_pkg::ADDR_RESHI, ex >> 16 & 'hffff, 'hffffffff);
		end
		$display("logic and multiply done");
		// Passes 4 and 5 use the 16-bit dividend with small operands
		for (int k = 0; k < 6; k++) begin
			d = ($urandom & (k[2] ? 'h7e : 'h7ffe)) + 1;
			q = ($urandom & (k[2] ? 'h7f : 'h3ff)) - ((k == 3) ? 'h400 : (k == 5) ? 'h80 : 0);
			r = ($urandom % d) * ((q < 0) ? -1 : 1);
			ex = q * d + r;
			bus(1'b1, core_pkg::ADDR_OPA, ex & 'hffff);
			bus(1'b1, core_pkg::ADDR_OPB, ex >> 16 & 'hffff);
			bus(1'b1, core_pkg::ADDR_RESHI, d);
			bus(1'b1, core_pkg::ADDR_CMD, (k[2] ? 32'h10 : 32'h0) |
				((k == 2 || k == 3 || k == 5) ? core_pkg::OP_DIVS : core_pkg::OP_DIVU));
			bus(1'b1, core_pkg::ADDR_CMD, core_pkg::OP_ADD);
			rck("busy", core_pkg::ADDR_STATUS, 'h10, 'h10);
			repeat (8) @(posedge hclk);
			rck("busy late", core_pkg::ADDR_STATUS, 'h10, 'h10);
			repeat (6) @(posedge hclk);
			rck("busy end", core_pkg::ADDR_STATUS, 'h0, 'h10);
			rck("quotient", core_pkg::ADDR_RES, q & 'hffff, 'hffff);
			rck("remainder", core_pkg::ADDR_RESHI, r & 'hffff, 'hffff);
		end
		// Double-word move copies both operands into the result pair
		a = $urandom & 'hffff;
		b = $urandom & 'hffff;
		bus(1'b1, core_pkg::ADDR_OPA, a);
		bus(1'b1, core_pkg::ADDR_OPB, b);
		bus(1'b1, core_pkg::ADDR_CMD, core_pkg::OP_MOVD);
		rck("move low", core_pkg::ADDR_RES, a, 'hffffffff);
		rck("move high", core_pkg::ADDR_RESHI, b, 'hffffffff);
		bus(1'b1, core_pkg::ADDR_CMD, core_pkg::OP_DIVU);
		abort_pulse();
		rck("divide abort", core_pkg::ADDR_STATUS, 'h0, 'h10);
		bus(1'b1, core_pkg::ADDR_CMD, {16'd200, 16'h000c});
		rck("loop active", core_pkg::ADDR_STATUS, 'h10, 'h10);
		abort_pulse();
		rck("loop abort", core_pkg::ADDR_STATUS, 'h0, 'h10);
		$display("divide and loop done");
		for (int i = 0; i < 16; i++) begin
			wv[i] = $urandom;
			bus(1'b1, core_pkg::ADDR_WREG + 8'(i * 4), wv[i]);
		end
		for (int i = 0; i < 16; i++) rck("working reg", core_pkg::ADDR_WREG + 8'(i * 4), wv[i] & 'hffff, 'hffffffff);
		bus(1'b1, core_pkg::ADDR_PC, 32'hffffffff);
		rck("program counter", core_pkg::ADDR_PC, 32'h7fffff, 32'hffffffff);
		bus(1'b1, core_pkg::ADDR_DSPACE, 32'h8000);
		rck("upper window", core_pkg::ADDR_DSPACE, 32'h80008000, 32'h8000ffff);
		bus(1'b1, core_pkg::ADDR_DSPACE, 32'h7fff);
		rck("linear space", core_pkg::ADDR_DSPACE, 32'h7fff, 32'h8000ffff);
		bus(1'b1, 8'h30, 32'hffffffff);
		rck("unmapped", 8'h30, 32'h0, 32'hffffffff);
		rck("source counts", core_pkg::ADDR_SRCCNT, (core_pkg::TRAP_SOURCES << 12) | core_pkg::IRQ_SOURCES, 'hffffffff);
		$display("register map done");
		close_out();
	end
endmodule : cpu_core_alu_status_test
`default_nettype wire
